// ### rtl/cpu_call_clear_decrement_ops.sv
// Execution unit for call, watchdog clear, clear, invert and decrement operations
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Functional notes
// - Call pushes current PC plus one onto the stack before jumping.
// - Call loads its 11-bit immediate into PC bits 10 to 0.
// - Call fills PC bits 12 and 11 from latch bits 4 and 3.
// - Call takes two instruction cycles and leaves every status flag alone.
// - Watchdog clear zeroes the watchdog counter and its prescaler.
// - Watchdog clear sets both expiry flag and sleep flag to one.
// - File clear writes zero to the register and sets the zero flag.
// - Accumulator clear loads zero and sets the zero flag, no operand.
// - Invert complements the register, routed by destination bit, zero flag only.
// - Decrement subtracts one, routed by destination bit, zero flag only.
// - Decrement-skip subtracts one, routed by destination bit, flags untouched.
// - Zero result discards the next instruction as a no-op, two cycles.
module cpu_call_clear_decrement_ops
(
   input  wire logic                               clk,
   input  wire logic                               nrst,
   input  wire cpu_ops_pkg::instr_s                instr,
   output logic                                    instrReady,
   input  wire cpu_ops_pkg::bus_req_s              busReq,
   output logic [cpu_ops_pkg::DATA_W-1:0]          busRdata,
   output logic [cpu_ops_pkg::PC_W-1:0]            pcOut,
   output logic [cpu_ops_pkg::PC_W-1:0]            stackHead,
   output logic                                    expiryFlag,
   output logic                                    sleepFlag
);
   import cpu_ops_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [DATA_W-1:0]   fileMem [FILE_N];
   logic [PC_W-1:0]     stackMem [STACK_N];
   logic [SPTR_W-1:0]   stackPtr_q;
   logic [PC_W-1:0]     pc_q;
   logic [DATA_W-1:0]   acc_q;
   logic                zero_q;
   logic                expiry_q;
   logic                sleep_q;
   logic [LATCH_W-1:0]  latch_q;
   logic [DATA_W-1:0]   wdog_q;
   logic [DATA_W-1:0]   presc_q;
   logic                skip_q;
   seq_e                seq_q;
   logic [DATA_W-1:0]   rdata_q;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic                taken;
   logic                exec;
   logic [5:0]          opc;
   logic [FADDR_W-1:0]  fAddr;
   logic                dest;
   logic                isCall;
   logic [DATA_W-1:0]   fileRd;
   logic [DATA_W-1:0]   decVal;
   logic [DATA_W-1:0]   result;
   logic                wrFile;
   logic                wrAcc;
   logic                updZero;
   logic                doCall;
   logic                doWdog;
   logic                setSkip;

   assign instrReady = (seq_q == SEQ_EXEC);
   assign taken      = instr.valid && instrReady;
   assign exec       = taken && !skip_q;
   assign opc        = instr.word[WORD_W-1:WORD_W-6];
   assign fAddr      = instr.word[FADDR_W-1:0];
   assign dest       = instr.word[DEST_BIT];
   assign isCall     = (instr.word[WORD_W-1:WORD_W-3] == OPC_CALL);
   assign fileRd     = fileMem[fAddr];
   assign decVal     = fileRd - 8'h01;

   always_comb
   begin
      result  = RST_DATA;
      wrFile  = 1'b0;
      wrAcc   = 1'b0;
      updZero = 1'b0;
      doCall  = 1'b0;
      doWdog  = 1'b0;
      setSkip = 1'b0;
      if (exec && isCall)
      begin
         doCall = 1'b1;
      end
      else if (exec)
      begin
         case (opc)
            OPC_CLRFILE:
            begin
               wrFile  = 1'b1;
               updZero = 1'b1;
            end
            OPC_CLRACC:
            begin
               wrAcc   = 1'b1;
               updZero = 1'b1;
            end
            OPC_INVERT:
            begin
               result  = ~fileRd;
               wrFile  = dest;
               wrAcc   = !dest;
               updZero = 1'b1;
            end
            OPC_DEC:
            begin
               result  = decVal;
               wrFile  = dest;
               wrAcc   = !dest;
               updZero = 1'b1;
            end
            OPC_DECSKIP:
            begin
               result  = decVal;
               wrFile  = dest;
               wrAcc   = !dest;
               setSkip = (decVal == RST_DATA);
            end
            OPC_CLRWDOG:
            begin
               doWdog  = 1'b1;
            end
            default:
            begin
               result  = RST_DATA;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Sequencer: call flush cycle and skip of next instruction
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         seq_q <= SEQ_EXEC;
      else
      begin
         case (seq_q)
            SEQ_EXEC:
               if (doCall)
                  seq_q <= SEQ_FLUSH;
            SEQ_FLUSH:
               seq_q <= SEQ_EXEC;
            default:
               seq_q <= SEQ_EXEC;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         skip_q <= 1'b0;
      else if (taken)
         skip_q <= setSkip;
   end

   // ----------------------------------------------------------------
   // Program counter and stack
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         pc_q <= RST_PC;
      else if (doCall)
         pc_q <= {latch_q[4:3], instr.word[CALL_K_MSB:0]};
      else if (taken)
         pc_q <= pc_q + 13'h0001;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         stackPtr_q <= '0;
      else if (doCall)
         stackPtr_q <= stackPtr_q + 3'h1;
   end

   always_ff @(posedge clk)
   begin
      if (doCall)
         stackMem[stackPtr_q] <= pc_q + 13'h0001;
   end

   assign stackHead = stackMem[stackPtr_q - 3'h1];
   assign pcOut     = pc_q;

   // ----------------------------------------------------------------
   // Accumulator, file registers and zero flag
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         acc_q <= RST_DATA;
      else if (wrAcc)
         acc_q <= result;
      else if (busReq.wr && busReq.addr == ADDR_ACC)
         acc_q <= busReq.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (wrFile)
         fileMem[fAddr] <= result;
      else if (busReq.wr && busReq.addr <= ADDR_FILE_LAST)
         fileMem[busReq.addr[FADDR_W-1:0]] <= busReq.wdata;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         zero_q <= 1'b0;
      else if (updZero)
         zero_q <= (result == RST_DATA);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         latch_q <= RST_LATCH;
      else if (busReq.wr && busReq.addr == ADDR_LATCH)
         latch_q <= busReq.wdata[LATCH_W-1:0];
   end

   // ----------------------------------------------------------------
   // Watchdog counter, prescaler and power flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         presc_q <= RST_DATA;
      else if (doWdog)
         presc_q <= RST_DATA;
      else
         presc_q <= presc_q + 8'h01;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         wdog_q <= RST_DATA;
      else if (doWdog)
         wdog_q <= RST_DATA;
      else if (presc_q == 8'hFF)
         wdog_q <= wdog_q + 8'h01;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         expiry_q <= RST_FLAG;
      else if (doWdog)
         expiry_q <= 1'b1;
      else if (presc_q == 8'hFF && wdog_q == 8'hFF)
         expiry_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sleep_q <= RST_FLAG;
      else if (doWdog)
         sleep_q <= 1'b1;
   end

   assign expiryFlag = expiry_q;
   assign sleepFlag  = sleep_q;

   // ----------------------------------------------------------------
   // Bus read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdata_q <= RST_DATA;
      else if (busReq.rd)
      begin
         if (busReq.addr <= ADDR_FILE_LAST)
            rdata_q <= fileMem[busReq.addr[FADDR_W-1:0]];
         else if (busReq.addr == ADDR_ACC)
            rdata_q <= acc_q;
         else if (busReq.addr == ADDR_STATUS)
            rdata_q <= {5'h00, expiry_q, sleep_q, zero_q};
         else if (busReq.addr == ADDR_LATCH)
            rdata_q <= {3'h0, latch_q};
         else if (busReq.addr == ADDR_PC_LO)
            rdata_q <= pc_q[7:0];
         else if (busReq.addr == ADDR_PC_HI)
            rdata_q <= {3'h0, pc_q[PC_W-1:8]};
         else if (busReq.addr == ADDR_WDOG)
            rdata_q <= wdog_q;
         else if (busReq.addr == ADDR_SPTR)
            rdata_q <= {5'h00, stackPtr_q};
         else
            rdata_q <= RST_DATA;
      end
      else
         rdata_q <= RST_DATA;
   end

   assign busRdata = rdata_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_call_push: assert property (doCall |=> stackHead == $past(pc_q) + 13'h0001)
      else $error("call did not push return address");
   chk_call_target: assert property (doCall |=> pc_q[CALL_K_MSB:0] == $past(instr.word[CALL_K_MSB:0]))
      else $error("call target not loaded");
   chk_call_upper: assert property (doCall |=> pc_q[PC_W-1:11] == $past(latch_q[4:3]))
      else $error("call upper bits wrong");
   chk_call_two: assert property (doCall |=> !instrReady && $stable(zero_q) ##1 instrReady)
      else $error("call not two cycles or flag moved");
   chk_wdog_clear: assert property (doWdog |=> wdog_q == 8'h00 && presc_q == 8'h00)
      else $error("watchdog not cleared");
   chk_wdog_flags: assert property (doWdog |=> expiryFlag && sleepFlag)
      else $error("power flags not set");
   chk_clear_file: assert property (exec && opc == OPC_CLRFILE |=> zero_q && acc_q == $past(acc_q))
      else $error("file clear wrong");
   chk_clear_acc: assert property (exec && !isCall && opc == OPC_CLRACC |=> acc_q == 8'h00 && zero_q)
      else $error("accumulator clear wrong");
   chk_invert_acc: assert property (exec && !isCall && opc == OPC_INVERT && !dest |=> acc_q == ~$past(fileRd))
      else $error("invert result wrong");
   chk_dec_zero: assert property (exec && !isCall && opc == OPC_DEC |=> zero_q == ($past(decVal) == 8'h00))
      else $error("decrement zero flag wrong");
   chk_decskip_flags: assert property (exec && !isCall && opc == OPC_DECSKIP |=> $stable(zero_q))
      else $error("decrement-skip touched flags");
   chk_skip_nop: assert property (taken && skip_q |=> $stable(acc_q) && $stable(zero_q) && !skip_q)
      else $error("skipped instruction not discarded");
   chk_dest_file: assert property (exec && !isCall && opc == OPC_DEC && dest |=> $stable(acc_q))
      else $error("destination bit ignored");

   cov_call: cover property (doCall ##2 taken);
   cov_skip: cover property (setSkip ##1 taken);
   cov_wdog: cover property (doWdog);
   cov_invert_file: cover property (exec && !isCall && opc == OPC_INVERT && dest);

endmodule // cpu_call_clear_decrement_ops

// ### rtl/cpu_ops_pkg.sv
// Package with constants and carriers for the call, clear and decrement execution block
package cpu_ops_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DATA_W    = 8;
   localparam int PC_W      = 13;
   localparam int WORD_W    = 14;
   localparam int FADDR_W   = 7;
   localparam int FILE_N    = 128;
   localparam int STACK_N   = 8;
   localparam int SPTR_W    = 3;
   localparam int BADDR_W   = 8;
   localparam int LATCH_W   = 5;

   // ----------------------------------------------------------------
   // Instruction word layout and opcodes
   // ----------------------------------------------------------------
   localparam int          CALL_K_MSB  = 10;
   localparam int          DEST_BIT    = 7;
   localparam logic [2:0]  OPC_CALL    = 3'h4;
   localparam logic [5:0]  OPC_NOP     = 6'h00;
   localparam logic [5:0]  OPC_CLRFILE = 6'h01;
   localparam logic [5:0]  OPC_CLRACC  = 6'h02;
   localparam logic [5:0]  OPC_INVERT  = 6'h03;
   localparam logic [5:0]  OPC_DEC     = 6'h04;
   localparam logic [5:0]  OPC_DECSKIP = 6'h05;
   localparam logic [5:0]  OPC_CLRWDOG = 6'h06;

   // ----------------------------------------------------------------
   // Register map of the plain bus port
   // ----------------------------------------------------------------
   localparam logic [BADDR_W-1:0] ADDR_FILE_LAST = 8'h7F;
   localparam logic [BADDR_W-1:0] ADDR_ACC       = 8'h80;
   localparam logic [BADDR_W-1:0] ADDR_STATUS    = 8'h81;
   localparam logic [BADDR_W-1:0] ADDR_LATCH     = 8'h82;
   localparam logic [BADDR_W-1:0] ADDR_PC_LO     = 8'h83;
   localparam logic [BADDR_W-1:0] ADDR_PC_HI     = 8'h84;
   localparam logic [BADDR_W-1:0] ADDR_WDOG      = 8'h85;
   localparam logic [BADDR_W-1:0] ADDR_SPTR      = 8'h86;

   // Status register bit positions
   localparam int STAT_ZERO   = 0;
   localparam int STAT_SLEEP  = 1;
   localparam int STAT_EXPIRY = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0]  RST_DATA  = 8'h00;
   localparam logic [PC_W-1:0]    RST_PC    = 13'h0000;
   localparam logic [LATCH_W-1:0] RST_LATCH = 5'h00;
   localparam logic               RST_FLAG  = 1'b1;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                valid;
      logic [WORD_W-1:0]   word;
   } instr_s;

   typedef struct packed {
      logic [BADDR_W-1:0]  addr;
      logic [DATA_W-1:0]   wdata;
      logic                wr;
      logic                rd;
   } bus_req_s;

   typedef enum logic {
      SEQ_EXEC  = 1'b0,
      SEQ_FLUSH = 1'b1
   } seq_e;

endpackage

// ### tb/cpu_call_clear_decrement_ops_test.sv
// Self-checking testbench for the call, clear and decrement execution block
`timescale 1ns/1ps
module cpu_call_clear_decrement_ops_test;
   import cpu_ops_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                clk;
   logic                nrst;
   instr_s              instr;
   logic                instrReady;
   bus_req_s            busReq;
   logic [DATA_W-1:0]   busRdata;
   logic [PC_W-1:0]     pcOut;
   logic [PC_W-1:0]     stackHead;
   logic                expiryFlag;
   logic                sleepFlag;
   logic [PC_W-1:0]     expPc;
   logic [LATCH_W-1:0]  expLatch;
   int                  nFail;
   int                  testsRun;
   int                  i;

   cpu_call_clear_decrement_ops u_dut (
      .clk(clk), .nrst(nrst), .instr(instr), .instrReady(instrReady),
      .busReq(busReq), .busRdata(busRdata), .pcOut(pcOut), .stackHead(stackHead),
      .expiryFlag(expiryFlag), .sleepFlag(sleepFlag));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         nFail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic busWrite(input logic [BADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq <= '0;
      @(posedge clk);
      if (a == ADDR_LATCH)
         expLatch = d[LATCH_W-1:0];
   endtask

   task automatic checkReg(input string name, input logic [BADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq <= '0;
      @(negedge clk);
      check(name, busRdata, exp);
      @(negedge clk);
      check("busRdata idle", busRdata, 8'h00);
      @(posedge clk);
   endtask

   // Offers wait for instrReady, so an offer right after a call is taken only after the flush cycle
   task automatic exec(input logic [WORD_W-1:0] w, input logic hold);
      int   guard;
      logic isCall;
      guard = 0;
      isCall = (w[WORD_W-1:CALL_K_MSB+1] == OPC_CALL);
      instr <= '{valid: 1'b1, word: w};
      @(negedge clk);
      while (instrReady !== 1'b1 && guard < 8)
      begin
         @(negedge clk);
         guard++;
      end
      @(posedge clk);
      expPc = isCall ? {expLatch[4:3], w[CALL_K_MSB:0]} : expPc + 13'h0001;
      if (!hold)
      begin
         instr.valid <= 1'b0;
         @(negedge clk);
         check("pcOut", pcOut, expPc);
         if (isCall)
            check("instrReady", instrReady, 1'b0);
         @(posedge clk);
      end
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      #320000;
      $display("ERROR watchdog expected completion seen hang");
      nFail++;
      conclude();
   end

   initial
   begin
      instr = '0;
      busReq = '0;
      nrst = 1'b0;
      expPc = '0;
      expLatch = '0;
      nFail = 0;
      testsRun = 0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      check("pcOut", pcOut, 13'h0000);
      check("expiryFlag", expiryFlag, 1'b1);
      check("sleepFlag", sleepFlag, 1'b1);
      @(posedge clk);
      checkReg("status", ADDR_STATUS, 8'h06);
      checkReg("unmapped", 8'h90, 8'h00);
      busWrite(ADDR_STATUS, 8'hFF);
      checkReg("status", ADDR_STATUS, 8'h06);
      $display("test reset done");

      exec({OPC_CLRACC, 8'h00}, 1'b0);
      busWrite(ADDR_LATCH, 8'hFF);
      checkReg("latch", ADDR_LATCH, 8'h1F);
      busWrite(ADDR_LATCH, 8'h18);
      exec({OPC_CALL, 11'h5A5}, 1'b0);
      check("stackHead", stackHead, 13'h0002);
      @(negedge clk);
      check("instrReady", instrReady, 1'b1);
      @(negedge clk);
      check("instrReady", instrReady, 1'b1);
      @(posedge clk);
      checkReg("status", ADDR_STATUS, 8'h07);
      busWrite(ADDR_LATCH, 8'h08);
      exec({OPC_CALL, 11'h7FF}, 1'b1);
      exec({OPC_NOP, 8'h00}, 1'b0);
      check("stackHead", stackHead, 13'h1DA6);
      checkReg("pcLo", ADDR_PC_LO, 8'h00);
      checkReg("pcHi", ADDR_PC_HI, 8'h10);
      checkReg("stackPtr", ADDR_SPTR, 8'h02);
      $display("test call done");

      repeat (600) @(posedge clk);
      exec({OPC_CLRWDOG, 8'h00}, 1'b0);
      checkReg("watchdog", ADDR_WDOG, 8'h00);
      repeat (200) @(posedge clk);
      checkReg("watchdog", ADDR_WDOG, 8'h00);
      repeat (100) @(posedge clk);
      checkReg("watchdog", ADDR_WDOG, 8'h01);
      $display("test watchdog clear done");

      busWrite(8'h20, 8'h02);
      busWrite(8'h7F, 8'hA5);
      exec({OPC_DEC, 1'b1, 7'h20}, 1'b0);
      checkReg("file20", 8'h20, 8'h01);
      checkReg("status", ADDR_STATUS, 8'h06);
      exec({OPC_CLRFILE, 1'b1, 7'h7F}, 1'b0);
      checkReg("file7F", 8'h7F, 8'h00);
      checkReg("status", ADDR_STATUS, 8'h07);
      exec({OPC_DEC, 1'b1, 7'h20}, 1'b0);
      checkReg("file20", 8'h20, 8'h00);
      exec({OPC_DEC, 1'b0, 7'h20}, 1'b0);
      checkReg("acc", ADDR_ACC, 8'hFF);
      checkReg("file20", 8'h20, 8'h00);
      checkReg("status", ADDR_STATUS, 8'h06);
      exec({OPC_CLRACC, 8'h00}, 1'b0);
      checkReg("acc", ADDR_ACC, 8'h00);
      checkReg("status", ADDR_STATUS, 8'h07);
      busWrite(8'h10, 8'h5A);
      exec({OPC_INVERT, 1'b0, 7'h10}, 1'b0);
      checkReg("acc", ADDR_ACC, 8'hA5);
      checkReg("file10", 8'h10, 8'h5A);
      checkReg("status", ADDR_STATUS, 8'h06);
      busWrite(8'h11, 8'hFF);
      exec({OPC_INVERT, 1'b1, 7'h11}, 1'b0);
      checkReg("file11", 8'h11, 8'h00);
      checkReg("acc", ADDR_ACC, 8'hA5);
      checkReg("status", ADDR_STATUS, 8'h07);
      $display("test clear invert decrement done");

      busWrite(8'h30, 8'h02);
      exec({OPC_DECSKIP, 1'b1, 7'h30}, 1'b1);
      exec({OPC_INVERT, 1'b0, 7'h30}, 1'b0);
      checkReg("file30", 8'h30, 8'h01);
      checkReg("acc", ADDR_ACC, 8'hFE);
      exec({OPC_DECSKIP, 1'b1, 7'h30}, 1'b0);
      checkReg("status", ADDR_STATUS, 8'h06);
      exec({OPC_INVERT, 1'b0, 7'h30}, 1'b0);
      exec({OPC_CLRACC, 8'h00}, 1'b0);
      exec({OPC_INVERT, 1'b0, 7'h30}, 1'b0);
      busWrite(8'h30, 8'h01);
      exec({OPC_DECSKIP, 1'b1, 7'h30}, 1'b1);
      exec({OPC_CLRACC, 8'h00}, 1'b0);
      checkReg("file30", 8'h30, 8'h00);
      checkReg("acc", ADDR_ACC, 8'hFF);
      checkReg("status", ADDR_STATUS, 8'h06);
      busWrite(8'h31, 8'h05);
      exec({OPC_DECSKIP, 1'b0, 7'h31}, 1'b1);
      exec({OPC_INVERT, 1'b1, 7'h31}, 1'b0);
      checkReg("acc", ADDR_ACC, 8'h04);
      checkReg("file31", 8'h31, 8'hFA);
      $display("test decrement skip done");

      for (i = 0; i < 70000 && expiryFlag !== 1'b0; i++)
         @(negedge clk);
      check("expiryFlag", expiryFlag, 1'b0);
      @(posedge clk);
      exec({OPC_CLRWDOG, 8'h00}, 1'b0);
      check("expiryFlag", expiryFlag, 1'b1);
      check("sleepFlag", sleepFlag, 1'b1);
      checkReg("status", ADDR_STATUS, 8'h06);
      checkReg("watchdog", ADDR_WDOG, 8'h00);
      $display("test time-out done");
      conclude();
   end

endmodule // cpu_call_clear_decrement_ops_test
